/* File: hdl/copro_handshake.sv */
// processor-side handshake with the numeric coprocessor
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Overview of operation
// - coordinate via own I/O cycles plus handshake lines
// - sample busy and error at instruction start
// - send opcode directly, no preamble cycles
// - wait opcode stalls until busy negates or an enabled interrupt or nmi breaks it
// - error at busy negation faults vector 16
// - opcodes to F8 port, operands to FC
// - handshake inputs honoured during hold acknowledge
// - sample error after reset to detect type
// ----------------------------------------------------------------------------
module copro_handshake
  import copro_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // core instruction side
  input wire logic instrValid,
  input wire logic [7:0] instrOpcode,
  input wire logic isCoproInstr,
  input wire logic [31:0] instrData,
  input wire logic interruptsEnabled,
  input wire logic nmiPending,
  input wire logic maskable_interrupt_input,
  input wire logic holdAck,
  output logic instrReady,
  output logic instrDone,
  output logic faultValid,
  output logic [7:0] faultVector,
  output logic waitBroken,
  output logic coproIsNewType,
  // coprocessor pins, active low busy and error
  input wire logic busyN,
  input wire logic errorN,
  input wire logic operand_transfer_request,
  // io cycle request toward the bus unit
  output logic ioReq,
  output logic [31:0] ioAddr,
  output logic [31:0] ioData,
  output logic address_bit_two,
  input wire logic ioAck
);
  typedef enum logic [1:0] {S_IDLE = 2'b00, S_WAITBUSY = 2'b01, S_OPCODE = 2'b10, S_OPERAND = 2'b11} state_t;

  // ----------------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------------
  logic [1:0] busyS_q, errS_q, reqS_q;
  logic [1:0] busyS_d, errS_d, reqS_d;
  // sync kept running under hold acknowledge so handshake is never lost
  always_comb
  begin
    busyS_d = {busyS_q[0], ~busyN};
    errS_d = {errS_q[0], ~errorN};
    reqS_d = {reqS_q[0], operand_transfer_request};
  end
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      busyS_q <= 2'b00;
      errS_q <= 2'b00;
      reqS_q <= 2'b00;
    end
    else
    begin
      busyS_q <= busyS_d;
      errS_q <= errS_d;
      reqS_q <= reqS_d;
    end
  end
  logic busy, err, xferReq;
  assign busy = busyS_q[1];
  assign err = errS_q[1];
  assign xferReq = reqS_q[1];

  // ----------------------------------------------------------------------------
  // post-reset coprocessor type detection
  // ----------------------------------------------------------------------------
  logic [7:0] rstCnt_q, rstCnt_d;
  logic newType_q, newType_d, firstBus_q, firstBus_d;
  always_comb
  begin
    rstCnt_d = (rstCnt_q == DETECT_START) ? rstCnt_q : rstCnt_q + 8'h01;
    firstBus_d = firstBus_q | ioReq;
    newType_d = newType_q;
    // latched once seen, so error negating before the first bus cycle cannot undo it
    if (rstCnt_q == DETECT_START && !firstBus_q)
      newType_d = newType_q | err;
  end
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      rstCnt_q <= 8'h00;
      newType_q <= 1'b0;
      firstBus_q <= 1'b0;
    end
    else
    begin
      rstCnt_q <= rstCnt_d;
      newType_q <= newType_d;
      firstBus_q <= firstBus_d;
    end
  end
  assign coproIsNewType = newType_q;

  // ----------------------------------------------------------------------------
  // instruction sequencer
  // ----------------------------------------------------------------------------
  state_t state_q, state_d;
  logic [31:0] addr_q, addr_d, data_q, data_d, opnd_q, opnd_d;
  logic req_q, req_d, done_q, done_d, fault_q, fault_d, brk_q, brk_d;
  logic intBreak;
  assign intBreak = nmiPending | (maskable_interrupt_input & interruptsEnabled);

  always_comb
  begin
    state_d = state_q;
    addr_d = addr_q;
    data_d = data_q;
    opnd_d = opnd_q;
    req_d = req_q;
    done_d = 1'b0;
    fault_d = 1'b0;
    brk_d = 1'b0;
    unique case (state_q)
      S_IDLE:
      begin
        if (instrValid && instrOpcode == WAIT_OPCODE)
          state_d = S_WAITBUSY;
        else if (instrValid && isCoproInstr && !busy && !err)
        begin
          // opcode goes straight out, no preamble cycle
          state_d = S_OPCODE;
          addr_d = OPCODE_PORT_ADDR;
          data_d = {24'h000000, instrOpcode};
          opnd_d = instrData;
          req_d = 1'b1;
        end
      end
      S_WAITBUSY:
      begin
        if (intBreak)
        begin
          state_d = S_IDLE;
          brk_d = 1'b1;
        end
        else if (!busy)
        begin
          state_d = S_IDLE;
          fault_d = err;
          done_d = ~err;
        end
      end
      S_OPCODE:
      begin
        if (ioAck)
        begin
          req_d = 1'b0;
          if (xferReq)
          begin
            // coprocessor asked for data: move the operand
            state_d = S_OPERAND;
            addr_d = OPERAND_PORT_ADDR;
            data_d = opnd_q;
            req_d = 1'b1;
          end
          else
          begin
            state_d = S_IDLE;
            done_d = 1'b1;
          end
        end
      end
      S_OPERAND:
      begin
        if (ioAck)
        begin
          req_d = 1'b0;
          state_d = S_IDLE;
          done_d = 1'b1;
        end
      end
    endcase
  end
  // bus is released while hold is granted; the request simply waits
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state_q <= S_IDLE;
      addr_q <= 32'h00000000;
      data_q <= 32'h00000000;
      opnd_q <= 32'h00000000;
      req_q <= 1'b0;
      done_q <= 1'b0;
      fault_q <= 1'b0;
      brk_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      addr_q <= addr_d;
      data_q <= data_d;
      opnd_q <= opnd_d;
      req_q <= req_d;
      done_q <= done_d;
      fault_q <= fault_d;
      brk_q <= brk_d;
    end
  end

  // outputs
  assign ioReq = req_q & ~holdAck;
  assign ioAddr = addr_q;
  assign ioData = data_q;
  assign address_bit_two = addr_q[ADDR_BIT_CMD];
  assign instrReady = (state_q == S_IDLE);
  assign instrDone = done_q;
  assign faultValid = fault_q;
  assign faultVector = fault_q ? FAULT_VECTOR : 8'h00;
  assign waitBroken = brk_q;

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  a_fault_on_error: assert property (@(posedge clock) disable iff (srst)
    (state_q == S_WAITBUSY && !intBreak && !busy && err) |=> faultValid && faultVector == 8'h10)
    else $error("wait with error did not fault");
  a_wait_holds_busy: assert property (@(posedge clock) disable iff (srst)
    (state_q == S_WAITBUSY && busy && !intBreak) |=> state_q == S_WAITBUSY)
    else $error("wait left while busy");
  a_opcode_port: assert property (@(posedge clock) disable iff (srst)
    (state_q == S_OPCODE) |-> ioAddr == 32'h800000f8 && address_bit_two == 1'b0)
    else $error("opcode port wrong");
  a_operand_port: assert property (@(posedge clock) disable iff (srst)
    (state_q == S_OPERAND) |-> ioAddr == 32'h800000fc && address_bit_two)
    else $error("operand port wrong");
  a_gate_on_busy: assert property (@(posedge clock) disable iff (srst)
    (state_q == S_IDLE && instrValid && isCoproInstr && instrOpcode != 8'h9b && busy) |=> state_q == S_IDLE)
    else $error("issued while busy");
  a_direct_opcode: assert property (@(posedge clock) disable iff (srst)
    (state_q == S_IDLE && instrValid && isCoproInstr && instrOpcode != 8'h9b && !busy && !err && !holdAck)
    |=> (ioReq || holdAck) && ioAddr == 32'h800000f8)
    else $error("opcode not issued at once");
  a_io_outside_pio: assert property (@(posedge clock) disable iff (srst)
    ioReq |-> ioAddr > PIO_LIMIT)
    else $error("io cycle inside programmed io range");
  a_type_frozen: assert property (@(posedge clock) disable iff (srst)
    firstBus_q |=> $stable(coproIsNewType))
    else $error("type changed after first bus cycle");
  a_sync_busy: assert property (@(posedge clock) disable iff (srst)
    ##2 (busy == !$past(busyN, 2)))
    else $error("busy sync lost");
  a_break_wait: assert property (@(posedge clock) disable iff (srst)
    (state_q == S_WAITBUSY && nmiPending) |=> waitBroken && state_q == S_IDLE)
    else $error("nmi did not break wait");
endmodule // copro_handshake

/* File: hdl/copro_pkg.sv */
// shared constants for the coprocessor handshake block
package copro_pkg;
  localparam logic [31:0] OPCODE_PORT_ADDR = 32'h800000f8;
  localparam logic [31:0] OPERAND_PORT_ADDR = 32'h800000fc;
  localparam logic [31:0] PIO_LIMIT = 32'h0000ffff;
  localparam logic [7:0] WAIT_OPCODE = 8'h9b;
  localparam logic [7:0] FAULT_VECTOR = 8'h10;
  localparam logic [7:0] DETECT_START = 8'h14;
  localparam int CLOCK_HZ = 10000000;
  localparam int ADDR_BIT_CMD = 2;
endpackage

/* File: testbench/copro_handshake_tb_top.sv */
// bench for the coprocessor handshake block
`timescale 1ns/1ps
module copro_handshake_tb_top;
  import copro_pkg::*;
  logic clock = 1'b0, srst = 1'b1, instrValid = 1'b0, isCoproInstr = 1'b0, interruptsEnabled = 1'b0;
  logic nmiPending = 1'b0, maskable_interrupt_input = 1'b0, holdAck = 1'b0, sawReq = 1'b0;
  logic wantBusy = 1'b0, wantError = 1'b1, wantOperand = 1'b0;
  logic [7:0] instrOpcode = 8'h00, faultVector, opcodeCount, operandCount;
  logic [31:0] instrData = 32'h1234abcd, ioAddr, ioData, firstAddr = 32'h0, lastAddr = 32'h0;
  logic [31:0] opWord = 32'h0, opndWord = 32'h0;
  logic instrReady, instrDone, faultValid, waitBroken, coproIsNewType, busyN, errorN;
  logic operand_transfer_request, ioReq, address_bit_two, ioAck;
  logic [2:0] ev;
  int mismatches = 0, samples_checked = 0, cycles = 0;
  copro_handshake u_copro_handshake (.clock, .srst, .instrValid, .instrOpcode, .isCoproInstr, .instrData,
    .interruptsEnabled, .nmiPending, .maskable_interrupt_input, .holdAck, .instrReady, .instrDone, .faultValid,
    .faultVector, .waitBroken, .coproIsNewType, .busyN, .errorN, .operand_transfer_request, .ioReq, .ioAddr,
    .ioData, .address_bit_two, .ioAck);
  copro_partner u_copro_partner (.clock, .wantBusy, .wantError, .wantOperand, .busyN, .errorN,
    .operand_transfer_request, .ioReq, .address_bit_two, .ioAck, .opcodeCount, .operandCount);
  // ----------------------------------------
  // clock, hang guard, io address capture
  // ----------------------------------------
  always #50 clock = ~clock;
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      mismatches++;
      report_and_stop;
    end
    if (ioReq === 1'b1)
    begin
      lastAddr <= ioAddr;
      if (!sawReq) firstAddr <= ioAddr;
      sawReq <= 1'b1;
    end
    // data words taken at the acknowledged edge, split by command select
    if (ioReq === 1'b1 && ioAck === 1'b1)
    begin
      if (address_bit_two) opndWord <= ioData;
      else opWord <= ioData;
    end
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // hold the request until the block leaves idle; bounded since refusal gives no sign
  task automatic send(input logic [7:0] op, input logic copro);
    @(posedge clock);
    instrValid <= 1'b1;
    instrOpcode <= op;
    isCoproInstr <= copro;
    for (int i = 0; i < 20 && instrReady !== 1'b0; i++)
    begin
      @(posedge clock);
      #1;
    end
    @(posedge clock);
    instrValid <= 1'b0;
  endtask
  task automatic waitEv(input int n);
    ev = 3'b000;
    for (int i = 0; i < n && ev == 3'b000; i++)
    begin
      @(posedge clock);
      #1;
      ev = {instrDone, faultValid, waitBroken};
      if (faultValid === 1'b1) chk(faultVector, FAULT_VECTOR);
    end
  endtask
  // refused while busy, then opcode word and operand word
  task automatic t_issue;
    wantBusy <= 1'b1;
    wantOperand <= 1'b1;
    fork
      send(8'hd9, 1'b1);
      begin
        repeat (6) @(posedge clock);
        chk(sawReq, 1'b0);
        chk(instrReady, 1'b1);
        wantBusy <= 1'b0;
      end
    join
    waitEv(30);
    chk(ev, 3'b100);
    chk(firstAddr, OPCODE_PORT_ADDR);
    chk(lastAddr, OPERAND_PORT_ADDR);
    chk({opcodeCount, operandCount}, 16'h0101);
    chk(opWord, {24'h000000, 8'hd9});
    chk(opndWord, instrData);
    chk(coproIsNewType, 1'b1);
    @(posedge clock);
    wantOperand <= 1'b0;
    $display("issue test done");
  endtask
  // modes: 0 release, 1 error, 2 enabled irq, 3 nmi, 4 release under hold
  task automatic t_wait(input int m);
    @(posedge clock);
    holdAck <= (m == 4);
    wantError <= (m == 1);
    wantBusy <= 1'b1;
    maskable_interrupt_input <= 1'b1;
    send(WAIT_OPCODE, 1'b0);
    waitEv(6);
    chk(ev, 3'b000);
    @(posedge clock);
    if (m == 2) interruptsEnabled <= 1'b1;
    else if (m == 3) nmiPending <= 1'b1;
    else wantBusy <= 1'b0;
    waitEv(10);
    chk(ev, (m == 1) ? 3'b010 : (m == 2 || m == 3) ? 3'b001 : 3'b100);
    @(posedge clock);
    {holdAck, wantError, wantBusy, maskable_interrupt_input, interruptsEnabled, nmiPending} <= 6'h00;
    repeat (3) @(posedge clock);
    $display("wait test %0d done", m);
  endtask
  // reset for 5 edges with error held at a level, then idle outputs and type
  task automatic t_reset(input logic errLevel);
    srst <= 1'b1;
    wantError <= errLevel;
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    repeat (25) @(posedge clock);
    #1;
    chk({instrReady, ioReq}, 2'b10);
    chk(coproIsNewType, errLevel);
    wantError <= 1'b0;
    $display("reset test %0d done", errLevel);
  endtask
  initial
  begin
    t_reset(1'b1);
    t_issue;
    for (int m = 0; m < 5; m++) t_wait(m);
    t_reset(1'b0);
    report_and_stop;
  end
endmodule // copro_handshake_tb_top

/* File: testbench/copro_partner.sv */
// coprocessor stand-in: status pins and io cycle answers
`timescale 1ns/1ps
module copro_partner (
  // clock
  input wire logic clock,
  // bench controls
  input wire logic wantBusy,
  input wire logic wantError,
  input wire logic wantOperand,
  // status pins, busy and error active low
  output logic busyN,
  output logic errorN,
  output logic operand_transfer_request,
  // io cycles and hit counters
  input wire logic ioReq,
  input wire logic address_bit_two,
  output logic ioAck,
  output logic [7:0] opcodeCount,
  output logic [7:0] operandCount
);
  logic [1:0] waitQ = 2'h0;
  // ----------------------------------------
  // pins and io answer
  // ----------------------------------------
  assign busyN = ~wantBusy;
  assign errorN = ~wantError;
  assign operand_transfer_request = wantOperand;
  initial
  begin
    ioAck = 1'b0;
    opcodeCount = 8'h00;
    operandCount = 8'h00;
  end
  // answer delay alternates so both prompt and slow acks occur
  always @(posedge clock)
  begin
    ioAck <= 1'b0;
    waitQ <= (ioReq && !ioAck) ? waitQ + 2'h1 : 2'h0;
    if (ioReq && !ioAck && waitQ == {opcodeCount[0], 1'b0})
    begin
      ioAck <= 1'b1;
      if (address_bit_two) operandCount <= operandCount + 8'h01;
      else opcodeCount <= opcodeCount + 8'h01;
    end
  end
endmodule // copro_partner
